//--- verilog/geom_cmd_defines.svh
// Purpose: constants for the geometry command decoder
// Assumes: header word carries the type in [31:24], sub-code in [23:16]
// Notes:   definitions only
`ifndef GEOM_CMD_DEFINES_SVH
`define GEOM_CMD_DEFINES_SVH

`define WORD_W          32
`define TYPE_HI         31
`define TYPE_LO         24
`define SUB_HI          23
`define SUB_LO          16
`define FIFO_DEPTH      8

`define T_NOP           8'h20
`define T_BEGIN         8'h21
`define T_END           8'h23
`define T_VERTEX        8'h30
`define T_VERTEX_LOG    8'h32
`define T_VERTEX_NOPLOG 8'h33
`define T_INIT          8'h40
`define T_VIEWPORT      8'h41
`define T_DEPTH         8'h42
`define T_MATRIX        8'h43
`define T_CLIP_XY       8'h44
`define T_CLIP_Z        8'h45
`define T_CLIP_W        8'h46
`define T_LINE2D        8'h72
`define T_LINE2D_ALT    8'h73
`define T_DRAW_MODE     8'hc0
`define T_GEOM_MODE     8'hc1
`define T_SHADOW_XY     8'hc8
`define T_SHADOW_Z      8'hc9
`define T_LOG_BASE      8'hcc
`define T_COLOUR        8'hce
`define T_BEGIN_EXT     8'he1
`define T_END_EXT       8'he3

// sub-code: upper nibble selects clipping, lower nibble the primitive
`define SUB_CLIP_NIB    4'h1
`define SUB_NCLIP_NIB   4'h3
`define P_POINTS        4'h0
`define P_LINES         4'h1
`define P_POLYGON       4'h2
`define P_TRIANGLES     4'h3
`define P_LINE_STRIP    4'h5
`define P_TRI_STRIP     4'h7
`define P_TRI_FAN       4'h8

`define FMT_FLOAT       2'h0
`define FMT_FIXED       2'h1
`define FMT_PACKED_XY   2'h3

`endif

//--- verilog/geom_cmd_pkg.sv
// Purpose: types shared by the geometry command decoder
// Assumes: nothing
// Notes:   codes are given by the enum order only
package geom_cmd_pkg;
    typedef enum logic [4:0] {
        op_none, op_nop, op_begin, op_end, op_begin_ext, op_end_ext,
        op_vertex, op_vertex_log, op_vertex_log_only, op_init,
        op_viewport, op_depth, op_matrix, op_clip_xy, op_clip_z, op_clip_w,
        op_line2d, op_draw_mode, op_geom_mode, op_shadow_xy, op_shadow_z,
        op_log_base, op_colour, op_illegal
    } op_e;

    typedef enum logic [2:0] {
        prim_points, prim_lines, prim_polygon, prim_triangles,
        prim_line_strip, prim_tri_strip, prim_tri_fan
    } prim_e;

    typedef enum logic [1:0] {
        prim_closed, prim_open_normal, prim_open_ext
    } prim_state_e;
endpackage

//--- verilog/cmd_fifo.sv
// Purpose: small synchronous FIFO between the display list and the decoder
// Assumes: single clock, synchronous active-low reset
// Notes:   full and empty are exact; no write while full, no read while empty
module cmd_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;

    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

//--- verilog/geometry_command_decoder.sv
// Purpose: decode geometry display-list header words into operations
// Assumes: headers only arrive here; parameter words are filtered upstream
// Notes:   one decoded header per accepted word, result held until taken
// Behaviour
// - 0x20 nop, 0x21 begin, 0x23 end
// - 0xe1 extended begin, 0xe3 extended end
// - 0x30 vertex draw, 0x32 draw and log
// - 0x33 logs coordinates only, no draw
// - 0x41 loads XY screen scale, offsets
// - 0x42 loads Z screen scale, offset
// - 0x43 loads transformation matrix
// - 0x44/0x45/0x46 load XY, Z, W clip
// - 0x72/0x73 pass to 2D line register
// - 0xc0 draw mode, 0xc1 geometry mode
// - 0xc8 loads shadow XY displacement
// - 0xc9 loads shadow, edge, interpolation Z
// - 0xcc loads coordinate log base address
// - 0xce loads body, shadow, edge colours
// - clipped sub-codes select seven primitives, integer
// - normal begin, select bit: triangles float
// - sub-codes 0x30-0x38 unclipped, integer XY
// - unclipped primitives accept only XY
// - select bit ignored: unclipped, extended begin
// - init resets engine, issued first
// - D field picks parameter format
`include "geom_cmd_defines.svh"
module geometry_command_decoder (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic                  cmd_valid,
    output logic                       cmd_ready,
    input  wire logic [`WORD_W-1:0]    cmd_word,
    input  wire logic                  fixed_point_select_bit,
    input  wire logic [1:0]            geometry_mode_d_field,
    input  wire logic                  dec_ready,
    output logic                       dec_valid,
    output geom_cmd_pkg::op_e          dec_op,
    output geom_cmd_pkg::prim_e        dec_prim,
    output logic                       dec_clipped,
    output logic                       dec_xy_float,
    output logic                       dec_xy_only,
    output logic                       dec_draws,
    output logic                       dec_logs,
    output logic [1:0]                 dec_param_format,
    output logic                       engine_reset,
    output logic                       engine_ready,
    output logic                       prim_open,
    output logic                       prim_extended,
    output logic                       sequence_error
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////
    // input buffering

    logic               hdr_valid;
    logic [`WORD_W-1:0] hdr_word;
    logic               hdr_take;

    cmd_fifo #(
        .WIDTH (`WORD_W),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset_n   (reset_n),
        .in_valid  (cmd_valid),
        .in_ready  (cmd_ready),
        .in_data   (cmd_word),
        .out_valid (hdr_valid),
        .out_ready (hdr_take),
        .out_data  (hdr_word)
    );

    ////////////////////////////////////////////////////////////////////////
    // field decode

    wire [7:0] type_code = hdr_word[`TYPE_HI:`TYPE_LO];
    wire [7:0] sub_code  = hdr_word[`SUB_HI:`SUB_LO];
    wire [3:0] sub_hi    = sub_code[7:4];
    wire [3:0] sub_lo    = sub_code[3:0];

    geom_cmd_pkg::op_e next_op;

    always_comb begin
        unique case (type_code)
            `T_NOP:           next_op = geom_cmd_pkg::op_nop;
            `T_BEGIN:         next_op = geom_cmd_pkg::op_begin;
            `T_END:           next_op = geom_cmd_pkg::op_end;
            `T_BEGIN_EXT:     next_op = geom_cmd_pkg::op_begin_ext;
            `T_END_EXT:       next_op = geom_cmd_pkg::op_end_ext;
            `T_VERTEX:        next_op = geom_cmd_pkg::op_vertex;
            `T_VERTEX_LOG:    next_op = geom_cmd_pkg::op_vertex_log;
            `T_VERTEX_NOPLOG: next_op = geom_cmd_pkg::op_vertex_log_only;
            `T_INIT:          next_op = geom_cmd_pkg::op_init;
            `T_VIEWPORT:      next_op = geom_cmd_pkg::op_viewport;
            `T_DEPTH:         next_op = geom_cmd_pkg::op_depth;
            `T_MATRIX:        next_op = geom_cmd_pkg::op_matrix;
            `T_CLIP_XY:       next_op = geom_cmd_pkg::op_clip_xy;
            `T_CLIP_Z:        next_op = geom_cmd_pkg::op_clip_z;
            `T_CLIP_W:        next_op = geom_cmd_pkg::op_clip_w;
            `T_LINE2D:        next_op = geom_cmd_pkg::op_line2d;
            `T_LINE2D_ALT:    next_op = geom_cmd_pkg::op_line2d;
            `T_DRAW_MODE:     next_op = geom_cmd_pkg::op_draw_mode;
            `T_GEOM_MODE:     next_op = geom_cmd_pkg::op_geom_mode;
            `T_SHADOW_XY:     next_op = geom_cmd_pkg::op_shadow_xy;
            `T_SHADOW_Z:      next_op = geom_cmd_pkg::op_shadow_z;
            `T_LOG_BASE:      next_op = geom_cmd_pkg::op_log_base;
            `T_COLOUR:        next_op = geom_cmd_pkg::op_colour;
            default:          next_op = geom_cmd_pkg::op_illegal;
        endcase
    end

    geom_cmd_pkg::prim_e next_prim;
    logic                prim_code_ok;

    always_comb begin
        prim_code_ok = 1'b1;
        unique case (sub_lo)
            `P_POINTS:     next_prim = geom_cmd_pkg::prim_points;
            `P_LINES:      next_prim = geom_cmd_pkg::prim_lines;
            `P_POLYGON:    next_prim = geom_cmd_pkg::prim_polygon;
            `P_TRIANGLES:  next_prim = geom_cmd_pkg::prim_triangles;
            `P_LINE_STRIP: next_prim = geom_cmd_pkg::prim_line_strip;
            `P_TRI_STRIP:  next_prim = geom_cmd_pkg::prim_tri_strip;
            `P_TRI_FAN:    next_prim = geom_cmd_pkg::prim_tri_fan;
            default: begin
                next_prim    = geom_cmd_pkg::prim_points;
                prim_code_ok = 1'b0;
            end
        endcase
    end

    wire is_begin     = (next_op == geom_cmd_pkg::op_begin);
    wire is_begin_ext = (next_op == geom_cmd_pkg::op_begin_ext);
    wire any_begin    = is_begin || is_begin_ext;
    wire sub_clipped  = (sub_hi == `SUB_CLIP_NIB);
    wire sub_nclip    = (sub_hi == `SUB_NCLIP_NIB);
    wire sub_ok       = prim_code_ok && (sub_clipped || sub_nclip);
    wire tri_family   = (next_prim == geom_cmd_pkg::prim_triangles) ||
                        (next_prim == geom_cmd_pkg::prim_tri_strip) ||
                        (next_prim == geom_cmd_pkg::prim_tri_fan);

    // float XY only for a clipped triangle family under the normal begin
    wire next_xy_float = is_begin && sub_clipped && tri_family
                         && fixed_point_select_bit;

    wire is_vertex    = (next_op == geom_cmd_pkg::op_vertex) ||
                        (next_op == geom_cmd_pkg::op_vertex_log) ||
                        (next_op == geom_cmd_pkg::op_vertex_log_only);
    wire is_end       = (next_op == geom_cmd_pkg::op_end) ||
                        (next_op == geom_cmd_pkg::op_end_ext);

    ////////////////////////////////////////////////////////////////////////
    // primitive bracket tracking

    geom_cmd_pkg::prim_state_e pstate;
    geom_cmd_pkg::prim_state_e next_pstate;
    logic                      cur_nclip;
    logic                      bad_seq;

    // malformed headers are still consumed; they raise sequence_error only
    always_comb begin
        next_pstate = pstate;
        bad_seq     = 1'b0;
        unique case (pstate)
            geom_cmd_pkg::prim_closed: begin
                if (is_begin && sub_ok) begin
                    next_pstate = geom_cmd_pkg::prim_open_normal;
                end else if (is_begin_ext && sub_ok) begin
                    next_pstate = geom_cmd_pkg::prim_open_ext;
                end else if (any_begin || is_vertex || is_end) begin
                    bad_seq = 1'b1;
                end
            end
            geom_cmd_pkg::prim_open_normal: begin
                if (next_op == geom_cmd_pkg::op_end) begin
                    next_pstate = geom_cmd_pkg::prim_closed;
                end else if (any_begin || is_end) begin
                    bad_seq = 1'b1;
                end
            end
            geom_cmd_pkg::prim_open_ext: begin
                if (next_op == geom_cmd_pkg::op_end_ext) begin
                    next_pstate = geom_cmd_pkg::prim_closed;
                end else if (any_begin || is_end) begin
                    bad_seq = 1'b1;
                end
            end
            default: begin
                next_pstate = geom_cmd_pkg::prim_closed;
            end
        endcase
        if (next_op == geom_cmd_pkg::op_init) begin
            next_pstate = geom_cmd_pkg::prim_closed;
        end
    end

    // the output stage is a single register; it stalls the FIFO when held
    assign hdr_take = hdr_valid && (!dec_valid || dec_ready);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pstate       <= geom_cmd_pkg::prim_closed;
            cur_nclip    <= 1'b0;
            engine_ready <= 1'b0;
        end else if (hdr_take) begin
            pstate <= next_pstate;
            // a refused nested begin must not retarget the open bracket
            if (any_begin && sub_ok && !prim_open) begin
                cur_nclip <= sub_nclip;
            end
            if (next_op == geom_cmd_pkg::op_init) begin
                engine_ready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output stage

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dec_valid <= 1'b0;
        end else if (hdr_take) begin
            dec_valid <= 1'b1;
        end else if (dec_ready) begin
            dec_valid <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dec_op           <= geom_cmd_pkg::op_none;
            dec_prim         <= geom_cmd_pkg::prim_points;
            dec_clipped      <= 1'b0;
            dec_xy_float     <= 1'b0;
            dec_xy_only      <= 1'b0;
            dec_draws        <= 1'b0;
            dec_logs         <= 1'b0;
            dec_param_format <= `FMT_FLOAT;
            engine_reset     <= 1'b0;
            sequence_error   <= 1'b0;
        end else if (hdr_take) begin
            dec_op           <= next_op;
            dec_prim         <= next_prim;
            dec_clipped      <= any_begin && sub_clipped;
            dec_xy_float     <= next_xy_float;
            dec_xy_only      <= is_vertex && cur_nclip;
            dec_draws        <= (next_op == geom_cmd_pkg::op_vertex) ||
                                (next_op == geom_cmd_pkg::op_vertex_log);
            dec_logs         <= (next_op == geom_cmd_pkg::op_vertex_log) ||
                                (next_op == geom_cmd_pkg::op_vertex_log_only);
            dec_param_format <= geometry_mode_d_field;
            engine_reset     <= (next_op == geom_cmd_pkg::op_init);
            sequence_error   <= bad_seq || (any_begin && !sub_ok);
        end else if (dec_ready) begin
            engine_reset <= 1'b0;
        end
    end

    assign prim_open     = (pstate != geom_cmd_pkg::prim_closed);
    assign prim_extended = (pstate == geom_cmd_pkg::prim_open_ext);

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_take_fp_tri;
        hdr_take && is_begin && sub_clipped && tri_family && fixed_point_select_bit;
    endsequence

    a_fp_float_tri: assert property (@(posedge clk) disable iff (!reset_n)
        s_take_fp_tri |=> dec_xy_float)
        else $error("normal begin triangle with select bit not float");

    a_ext_int_xy: assert property (@(posedge clk) disable iff (!reset_n)
        hdr_take && (is_begin_ext || sub_nclip) |=> !dec_xy_float)
        else $error("select bit not ignored");

    a_ext_bracket: assert property (@(posedge clk) disable iff (!reset_n)
        hdr_take && pstate == geom_cmd_pkg::prim_closed && is_begin_ext && sub_ok
        |=> prim_extended)
        else $error("extended begin did not open extended primitive");

    a_log_no_draw: assert property (@(posedge clk) disable iff (!reset_n)
        hdr_take && type_code == `T_VERTEX_NOPLOG |=> dec_logs && !dec_draws)
        else $error("log-only vertex drew");

    a_draw_log: assert property (@(posedge clk) disable iff (!reset_n)
        hdr_take && type_code == `T_VERTEX_LOG |=> dec_logs && dec_draws)
        else $error("draw-and-log vertex wrong");

    a_init_resets: assert property (@(posedge clk) disable iff (!reset_n)
        hdr_take && type_code == `T_INIT |=> engine_reset && engine_ready && !prim_open)
        else $error("init did not reset engine");

    a_nclip_xy_only: assert property (@(posedge clk) disable iff (!reset_n)
        hdr_take && is_vertex && cur_nclip |=> dec_xy_only)
        else $error("unclipped vertex not xy only");

    a_line2d_pass: assert property (@(posedge clk) disable iff (!reset_n)
        hdr_take && type_code == `T_LINE2D_ALT |=> dec_op == geom_cmd_pkg::op_line2d)
        else $error("2d line pass-through missed");

    a_colour_op: assert property (@(posedge clk) disable iff (!reset_n)
        hdr_take && type_code == `T_COLOUR |=> dec_op == geom_cmd_pkg::op_colour)
        else $error("colour command missed");

    a_hold_output: assert property (@(posedge clk) disable iff (!reset_n)
        dec_valid && !dec_ready |=> dec_valid && $stable(dec_op))
        else $error("decoded output dropped under stall");

    a_nop_op: assert property (
        hdr_take && type_code == `T_NOP |=> dec_op == geom_cmd_pkg::op_nop)
        else $error("nop decoded wrong");

    a_begin_opens: assert property (
        hdr_take && !prim_open && is_begin && sub_ok |=> prim_open && !prim_extended)
        else $error("normal begin did not open");

    a_ext_close: assert property (
        hdr_take && prim_extended && next_op == geom_cmd_pkg::op_end_ext |=> !prim_open)
        else $error("extended end did not close");

    a_nclip_int: assert property (
        hdr_take && any_begin && sub_nclip |=> !dec_clipped && !dec_xy_float)
        else $error("unclipped begin not integer");

    a_bad_sub_err: assert property (
        hdr_take && !prim_open && any_begin && !sub_ok |=> sequence_error && !prim_open)
        else $error("bad sub-code accepted");

    a_fan_prim: assert property (
        hdr_take && any_begin && sub_lo == `P_TRI_FAN
        |=> dec_prim == geom_cmd_pkg::prim_tri_fan)
        else $error("fan sub-code wrong");

    a_fmt_follow: assert property (
        hdr_take |=> dec_param_format == $past(geometry_mode_d_field))
        else $error("format field not copied");
endmodule

//--- test/display_list_host.sv
// Purpose: display list feeder standing in for the host or DMA
// Assumes: one header word per transfer, offered after a falling edge
// Notes:   word is held until a rising edge sees cmd_ready; slow inserts gaps
module display_list_host (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        cmd_ready,
    input  wire logic        slow,
    output logic             cmd_valid,
    output logic [31:0]      cmd_word
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] pending[$];
    int          accepted = 0;
    int          gap = 0;
    logic        took = 1'b0;

    initial begin
        cmd_valid = 1'b0;
        cmd_word = 32'h0;
    end

    task automatic push(input logic [31:0] w);
        pending.push_back(w);
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        took <= reset_n && cmd_valid && cmd_ready;
        if (reset_n && cmd_valid && cmd_ready) begin
            accepted <= accepted + 1;
        end
    end

    // an idle bus inverts every bit each falling edge, so the last header returns every other cycle
    always @(negedge clk) begin
        if (reset_n && (!cmd_valid || took)) begin
            if (gap > 0 || pending.size() == 0) begin
                cmd_valid <= 1'b0;
                cmd_word <= ~cmd_word;
                gap <= (gap > 0) ? gap - 1 : 0;
            end else begin
                cmd_valid <= 1'b1;
                cmd_word <= pending.pop_front();
                gap <= slow ? accepted % 3 : 0;
            end
        end
    end
endmodule

//--- test/tb_geometry_command_decoder.sv
// Purpose: self-checking bench for the geometry command decoder
// Assumes: fixed-point select and format field change only when drained
// Notes:   expected results come from a queue filled as words are pushed
module tb_geometry_command_decoder;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [4:0] op;
        logic [2:0] prim;
        logic       clipped, xyf, xyo, draws, logs;
        logic [1:0] fmt;
        logic       err, open, ext, full, beg;
    } exp_s;
    logic                clk = 1'b0, reset_n = 1'b0, fp_sel = 1'b0, slow = 1'b0;
    logic                dec_ready = 1'b0, stall = 1'b0;
    logic [1:0]          d_field = 2'h0;
    logic                cmd_valid, cmd_ready, dec_valid, dec_clipped, dec_xy_float;
    logic                dec_xy_only, dec_draws, dec_logs, engine_reset, engine_ready;
    logic                prim_open, prim_extended, sequence_error;
    logic [31:0]         cmd_word, seed = 32'h33;
    logic [1:0]          dec_param_format;
    geom_cmd_pkg::op_e   dec_op;
    geom_cmd_pkg::prim_e dec_prim;
    exp_s                exp_q[$];
    exp_s                cur;
    int                  n_errors = 0, checks_done = 0, cycles = 0, base;
    logic                st_open = 0, st_ext = 0, st_nclip = 0, init_seen = 0;
    logic [7:0] codes [22] = '{8'h20, 8'h21, 8'h23, 8'he1, 8'he3, 8'h30, 8'h32, 8'h33,
        8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h72, 8'hc0, 8'hc1, 8'hc8,
        8'hc9, 8'hcc, 8'hce};
    logic [2:0] prim_of [9] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h0, 3'h4, 3'h0, 3'h5, 3'h6};

    always #50 clk = ~clk;

    geometry_command_decoder geometry_command_decoder_i (.clk(clk), .reset_n(reset_n),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_word(cmd_word),
        .fixed_point_select_bit(fp_sel), .geometry_mode_d_field(d_field),
        .dec_ready(dec_ready), .dec_valid(dec_valid), .dec_op(dec_op),
        .dec_prim(dec_prim), .dec_clipped(dec_clipped), .dec_xy_float(dec_xy_float),
        .dec_xy_only(dec_xy_only), .dec_draws(dec_draws), .dec_logs(dec_logs),
        .dec_param_format(dec_param_format), .engine_reset(engine_reset),
        .engine_ready(engine_ready), .prim_open(prim_open),
        .prim_extended(prim_extended), .sequence_error(sequence_error));
    display_list_host display_list_host_i (.clk(clk), .reset_n(reset_n),
        .cmd_ready(cmd_ready), .slow(slow), .cmd_valid(cmd_valid), .cmd_word(cmd_word));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // bench model: one expected result per header, in order
    task automatic expect_word(input logic [31:0] w);
        exp_s       e;
        logic [7:0] t, s;
        logic       ok;
        t = w[31:24];
        s = w[23:16];
        e = '0;
        e.op = 5'd23;
        for (int i = 0; i < 22; i++) if (t == codes[i]) e.op = 5'(i + 1);
        if (t == 8'h73) e.op = 5'd16;
        e.fmt = d_field;
        e.draws = (t == 8'h30 || t == 8'h32);
        e.logs = (t == 8'h32 || t == 8'h33);
        ok = (s[7:4] == 4'h1 || s[7:4] == 4'h3) && s[3:0] inside {0, 1, 2, 3, 5, 7, 8};
        if (t == 8'h21 || t == 8'he1) begin
            e.beg = 1'b1;
            e.err = st_open || !ok;
            if (!e.err) begin
                st_open = 1'b1;
                st_ext = (t == 8'he1);
                st_nclip = (s[7:4] == 4'h3);
                e.prim = prim_of[s[3:0]];
                e.clipped = !st_nclip;
                e.xyf = fp_sel && t == 8'h21 && !st_nclip && s[3:0] inside {3, 7, 8};
            end
        end else if (t == 8'h23 || t == 8'he3) begin
            e.err = !st_open || (st_ext != (t == 8'he3));
            if (!e.err) st_open = 1'b0;
        end else if (t inside {8'h30, 8'h32, 8'h33}) begin
            e.err = !st_open;
            e.xyo = st_open && st_nclip;
        end else if (t == 8'h40) begin
            st_open = 1'b0;
        end
        e.full = !e.err;
        e.open = st_open;
        e.ext = st_open && st_ext;
        exp_q.push_back(e);
        display_list_host_i.push(w);
    endtask

    task automatic drain();
        int k;
        k = 0;
        while (exp_q.size() != 0 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        if (k >= 3000) check("drain", 8'h1, 8'h0);
        repeat (2) @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    always @(negedge clk) dec_ready <= stall ? 1'b0 : (xs() % 4 != 0);

    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            report_and_stop();
        end else if (reset_n && dec_valid === 1'b1 && dec_ready) begin
            if (exp_q.size() == 0) begin
                check("spare", 8'h1, 8'h0);
            end else begin
                cur = exp_q.pop_front();
                check("op", dec_op, cur.op);
                check("seq_err", sequence_error, cur.err);
                check("open", prim_open, cur.open);
                check("ext", prim_extended, cur.ext);
                check("fmt", dec_param_format, cur.fmt);
                check("draws", dec_draws, cur.draws);
                check("logs", dec_logs, cur.logs);
                check("eng_rst", engine_reset, cur.op == 5'd9);
                if (cur.full && cur.beg) check("prim", dec_prim, cur.prim);
                if (cur.full) check("clipped", dec_clipped, cur.clipped);
                if (cur.full) check("xy_float", dec_xy_float, cur.xyf);
                if (cur.full) check("xy_only", dec_xy_only, cur.xyo);
                if (cur.op != 5'd9) check("eng_rdy", engine_ready, init_seen);
                if (cur.op == 5'd9) init_seen = 1'b1;
            end
        end
    end

    initial begin
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        expect_word(32'h2000_0000);
        expect_word(32'h4000_0000);
        drain();
        // every type code but 0x21, 0x23, 0xe1 and 0xe3, with noise in the lower bytes
        for (int i = 0; i < 22; i++) if (i < 1 || i > 4) expect_word({codes[i], 24'(xs())});
        expect_word({8'h73, 24'(xs())});
        expect_word({8'h22, 24'(xs())});
        expect_word({8'hff, 24'(xs())});
        drain();
        for (int f = 0; f < 2; f++) begin
            fp_sel = f[0];
            slow = f[0];
            d_field = f[0] ? 2'h3 : 2'h1;
            for (int b = 0; b < 2; b++) for (int n = 1; n < 4; n += 2)
            for (int p = 0; p < 9; p++) begin
                if (p == 4 || p == 6) continue;
                expect_word({b ? 8'he1 : 8'h21, 4'(n), 4'(p), 16'(xs())});
                expect_word(32'h3000_0000);
                expect_word(32'h3200_0000);
                expect_word(32'h3300_0000);
                expect_word({b ? 8'he3 : 8'h23, 24'h0});
            end
            drain();
        end
        // refused sub-codes, stray ends, init closing an open bracket
        expect_word(32'h2114_0000);
        expect_word(32'h2124_0000);
        expect_word(32'h2119_0000);
        expect_word(32'he300_0000);
        expect_word(32'h2300_0000);
        expect_word(32'h2110_0000);
        expect_word(32'h2130_0000);
        expect_word(32'h3000_0000);
        expect_word(32'h4000_0000);
        expect_word(32'h2300_0000);
        drain();
        // output register plus eight queued words, then refusal
        stall = 1'b1;
        base = display_list_host_i.accepted;
        repeat (12) expect_word({16'h2000, 16'(xs())});
        repeat (30) @(negedge clk);
        check("accepted", 8'(display_list_host_i.accepted - base), 8'd9);
        check("cmd_ready", cmd_ready, 8'h0);
        stall = 1'b0;
        drain();
        report_and_stop();
    end
endmodule
